// file: include/ccr_pkg.sv
// Constants for the CPU control register bank
package ccr_pkg;
   localparam logic [7:0]  CCR_OFS_GUARD    = 8'h04;
   localparam logic [7:0]  CCR_OFS_SP_LOW   = 8'h0d;
   localparam logic [7:0]  CCR_OFS_SP_HIGH  = 8'h0e;
   localparam logic [7:0]  CCR_OFS_FLAGS    = 8'h0f;
   localparam logic [7:0]  CCR_CODE_IO      = 8'hd8;
   localparam logic [7:0]  CCR_CODE_SPM     = 8'h9d;
   localparam logic [7:0]  CCR_FLAGS_RESET  = 8'h00;
   localparam logic [2:0]  CCR_WINDOW_INSTR = 3'h4;
   localparam int          CCR_SP_BITS      = 11;
   localparam logic [15:0] CCR_SP_RESET     = 16'h07ff;
   localparam int          CCR_BIT_I        = 7;
   localparam int          CCR_BIT_T        = 6;
   localparam int          CCR_BIT_H        = 5;
   localparam int          CCR_BIT_S        = 4;
   localparam int          CCR_BIT_V        = 3;
   localparam int          CCR_BIT_N        = 2;
   localparam int          CCR_BIT_Z        = 1;
   localparam int          CCR_BIT_C        = 0;
endpackage

// file: include/ccr_win_if.sv
// Window counter signals between the register bank and its counter
`timescale 1ns/100ps
interface ccr_win_if;
   logic       start;
   logic       cancel;
   logic       instr;
   logic       open;
   modport bank (output start, output cancel, output instr, input open);
   modport cnt  (input start, input cancel, input instr, output open);
endinterface

// file: rtl/ccr_window.sv
// Four-instruction window counter
`timescale 1ns/100ps
module ccr_window
   import ccr_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   ccr_win_if.cnt    win
);
   logic [2:0] count;
   logic [2:0] next_count;

   always_comb
   begin
      next_count = count;
      if (win.start)
         next_count = CCR_WINDOW_INSTR;
      else if (win.cancel)
         next_count = 3'h0;
      else if (win.instr && count != 3'h0)
         next_count = count - 3'h1;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
         count <= 3'h0;
      else
         count <= next_count;
   end

   assign win.open = (count != 3'h0);
endmodule

// file: rtl/ccr_bank.sv
// CPU control register bank: change guard, stack pointer, flags
// Operation
// - Guard recognises 0xd8 for protected I/O and 0x9d for self-programming.
// - Unlock lasts for the next four executed instructions only.
// - No interrupt is taken while an unlock window is open.
// - Guard bit 0 reads one while the protected I/O unlock is open.
// - Guard bit 1 reads one while the self-programming unlock is open.
// - Guard bits 7 to 2 always read zero.
// - I/O unlock cancelled by other writes, memory access or sleep.
// - Stack pointer resets to the top of internal SRAM.
// - Only needed stack pointer bits exist; the rest read zero.
// - Stack pointer low byte at base, high byte at base plus one.
// - Low byte write blocks interrupts four instructions or until I/O write.
// - Flag bit 7 is the global interrupt enable.
// - Taking an interrupt never clears the global enable.
// - Dedicated instructions set and clear the global enable.
// - Changing the enable over the register path costs one wait cycle.
// - Flag bit 6 is the bit copy store, used by bit store and load.
// - Sign flag is negative xor overflow.
// - Flags: half carry 5, overflow 3, negative 2, zero 1, carry 0; reset zero.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module ccr_bank
   import ccr_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic       i_instr_done,
   input  wire logic       i_mem_write,
   input  wire logic       i_nvm_access,
   input  wire logic       i_sleep,
   input  wire logic       i_irq_allow_instr,
   input  wire logic       i_irq_block_instr,
   input  wire logic       i_bit_store_instr,
   input  wire logic       i_bit_store_value,
   input  wire logic       i_alu_flags_we,
   input  wire logic [4:0] i_alu_flags,
   input  wire logic       i_irq_taken,
   output logic [7:0]      o_rdata,
   output logic            o_wait,
   output logic            o_irq_enable,
   output logic            o_irq_inhibit,
   output logic            o_protected_io_unlock,
   output logic            o_self_program_unlock,
   output logic            o_bit_copy,
   output logic [15:0]     o_stack_pointer
);
   ccr_win_if io_win ();
   ccr_win_if spm_win ();
   ccr_win_if sp_win ();

   ccr_window u_io_win  (.i_clk(i_clk), .i_reset_n(i_reset_n), .win(io_win));
   ccr_window u_spm_win (.i_clk(i_clk), .i_reset_n(i_reset_n), .win(spm_win));
   ccr_window u_sp_win  (.i_clk(i_clk), .i_reset_n(i_reset_n), .win(sp_win));

   logic wr_guard;
   logic wr_sp_low;
   logic wr_sp_high;
   logic wr_flags;
   logic other_write;

   assign wr_guard    = i_wr && (i_addr == CCR_OFS_GUARD);
   assign wr_sp_low   = i_wr && (i_addr == CCR_OFS_SP_LOW);
   assign wr_sp_high  = i_wr && (i_addr == CCR_OFS_SP_HIGH);
   assign wr_flags    = i_wr && (i_addr == CCR_OFS_FLAGS);
   // The unlocking write itself must not cancel its own window
   assign other_write = (i_wr && !wr_guard) || i_mem_write;

   // Windows
   assign io_win.start  = wr_guard && (i_wdata == CCR_CODE_IO);
   assign io_win.cancel = other_write || i_nvm_access || i_sleep;
   assign io_win.instr  = i_instr_done;
   assign spm_win.start  = wr_guard && (i_wdata == CCR_CODE_SPM);
   assign spm_win.cancel = i_nvm_access || i_sleep;
   assign spm_win.instr  = i_instr_done;
   assign sp_win.start  = wr_sp_low;
   assign sp_win.cancel = i_wr && !wr_sp_low;
   assign sp_win.instr  = i_instr_done;

   // Stack pointer, only the addressable bits stored
   logic [CCR_SP_BITS-1:0] sp;
   logic [CCR_SP_BITS-1:0] next_sp;
   logic [7:0]             flags;
   logic [7:0]             next_flags;
   logic                   wait_q;
   logic                   next_wait;
   logic [7:0]             rdata;
   logic [7:0]             next_rdata;
   logic [15:0]            sp_full;

   assign sp_full = {{(16 - CCR_SP_BITS){1'b0}}, sp};

   always_comb
   begin
      next_sp = sp;
      if (wr_sp_low)
         next_sp[7:0] = i_wdata;
      if (wr_sp_high)
         next_sp[CCR_SP_BITS-1:8] = i_wdata[CCR_SP_BITS-9:0];
   end

   always_comb
   begin
      next_flags = flags;
      next_wait  = 1'b0;
      if (i_alu_flags_we)
      begin
         next_flags[CCR_BIT_H] = i_alu_flags[4];
         next_flags[CCR_BIT_V] = i_alu_flags[3];
         next_flags[CCR_BIT_N] = i_alu_flags[2];
         next_flags[CCR_BIT_Z] = i_alu_flags[1];
         next_flags[CCR_BIT_C] = i_alu_flags[0];
      end
      if (i_bit_store_instr)
         next_flags[CCR_BIT_T] = i_bit_store_value;
      if (wr_flags)
      begin
         next_flags = i_wdata;
         next_wait  = (i_wdata[CCR_BIT_I] != flags[CCR_BIT_I]);
      end
      // Only software changes the enable; i_irq_taken is ignored here
      if (i_irq_allow_instr)
         next_flags[CCR_BIT_I] = 1'b1;
      else if (i_irq_block_instr)
         next_flags[CCR_BIT_I] = 1'b0;
      // Sign is derived, never stored independently
      next_flags[CCR_BIT_S] = next_flags[CCR_BIT_N] ^ next_flags[CCR_BIT_V];
   end

   always_comb
   begin
      next_rdata = 8'h00;
      if (i_rd)
      begin
         unique case (i_addr)
            CCR_OFS_GUARD:   next_rdata = {6'h00, spm_win.open, io_win.open};
            CCR_OFS_SP_LOW:  next_rdata = sp_full[7:0];
            CCR_OFS_SP_HIGH: next_rdata = sp_full[15:8];
            CCR_OFS_FLAGS:   next_rdata = flags;
            default:         next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         sp     <= CCR_SP_RESET[CCR_SP_BITS-1:0];
         flags  <= CCR_FLAGS_RESET;
         wait_q <= 1'b0;
         rdata  <= 8'h00;
      end
      else
      begin
         sp     <= next_sp;
         flags  <= next_flags;
         wait_q <= next_wait;
         rdata  <= next_rdata;
      end
   end

   // Output flops
   logic next_inhibit;
   // A cancelling write releases interrupts at once, not one cycle late
   assign next_inhibit = io_win.start || spm_win.start || sp_win.start
                         || (io_win.open && !io_win.cancel)
                         || (spm_win.open && !spm_win.cancel)
                         || (sp_win.open && !sp_win.cancel);

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         o_irq_inhibit         <= 1'b0;
         o_protected_io_unlock <= 1'b0;
         o_self_program_unlock <= 1'b0;
      end
      else
      begin
         o_irq_inhibit         <= next_inhibit;
         o_protected_io_unlock <= io_win.open && !io_win.cancel;
         o_self_program_unlock <= spm_win.open && !spm_win.cancel;
      end
   end

   assign o_rdata         = rdata;
   assign o_wait          = wait_q;
   assign o_irq_enable    = flags[CCR_BIT_I];
   assign o_bit_copy      = flags[CCR_BIT_T];
   assign o_stack_pointer = sp_full;

   // Checks
   sign_xor_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      flags[CCR_BIT_S] == (flags[CCR_BIT_N] ^ flags[CCR_BIT_V]))
      else $error("sign flag not n xor v");
   guard_high_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $past(i_rd) |-> (($past(i_addr) != CCR_OFS_GUARD) || o_rdata[7:2] == 6'h00))
      else $error("guard upper bits not zero");
   io_unlock_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (wr_guard && i_wdata == CCR_CODE_IO) |=> io_win.open)
      else $error("io unlock did not open");
   bad_code_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (wr_guard && i_wdata != CCR_CODE_IO && !io_win.open) |=> !io_win.open)
      else $error("bad code opened window");
   window_len_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (spm_win.start ##1 (i_instr_done && !spm_win.cancel && !spm_win.start) [*4])
      |=> !spm_win.open)
      else $error("window longer than four");
   cancel_io_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_sleep && !io_win.start) |=> !io_win.open)
      else $error("sleep did not cancel");
   inhibit_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      wr_sp_low |=> o_irq_inhibit)
      else $error("no inhibit after sp low write");
   wait_i_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (wr_flags && i_wdata[CCR_BIT_I] != flags[CCR_BIT_I]) |=> o_wait ##1 !o_wait)
      else $error("enable change wait wrong");
   keep_i_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (i_irq_taken && !wr_flags && !i_irq_block_instr && o_irq_enable) |=> o_irq_enable)
      else $error("enable cleared by hardware");
   sei_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_irq_allow_instr |=> o_irq_enable)
      else $error("allow instr failed");
endmodule

// file: tb/ccr_core_model.sv
// Execution core stand-in that retires instructions on request
`timescale 1ns/100ps
module ccr_core_model
   import ccr_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   input  wire logic i_run,
   input  wire logic i_slow,
   output logic      o_instr_done
);
   logic [1:0] phase;
   // Slow mode retires one instruction every third cycle
   always_ff @(posedge i_clk)
      phase <= (!i_reset_n || phase == 2'h2) ? 2'h0 : phase + 2'h1;
   assign o_instr_done = i_run & (!i_slow | phase == 2'h0);
endmodule

// file: tb/tb_cpu_control_register_bank.sv
// Testbench for the CPU control register bank
`timescale 1ns/100ps
module tb_cpu_control_register_bank
   import ccr_pkg::*;
;
   logic        i_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, run = 0, slow = 0;
   logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, pl = 8'h00, rdata;
   logic        instr, bsv = 0, wt, ien, inh, iou, spu, bc;
   logic [4:0]  alu = 5'h00;
   logic [15:0] sp;
   int          n_fail = 0, checked = 0;
   always #5 i_clk = ~i_clk;
   ccr_core_model u_ccr_core_model (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_run(run),
      .i_slow(slow), .o_instr_done(instr));
   ccr_bank u_ccr_bank (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_instr_done(instr),
      .i_mem_write(pl[0]), .i_nvm_access(pl[1]), .i_sleep(pl[2]),
      .i_irq_allow_instr(pl[3]), .i_irq_block_instr(pl[4]), .i_bit_store_instr(pl[6]),
      .i_bit_store_value(bsv), .i_alu_flags_we(pl[7]), .i_alu_flags(alu),
      .i_irq_taken(pl[5]), .o_rdata(rdata), .o_wait(wt), .o_irq_enable(ien),
      .o_irq_inhibit(inh), .o_protected_io_unlock(iou), .o_self_program_unlock(spu),
      .o_bit_copy(bc), .o_stack_pointer(sp));
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e)
      begin
         n_fail++;
         $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic pulse(input int k);
      @(posedge i_clk);
      pl[k] <= 1'b1;
      @(posedge i_clk);
      pl <= 8'h00;
      #1;
   endtask
   // Retire n instructions; a stuck core ends the run
   task automatic retire(input int n);
      int seen = 0;
      int lim  = 0;
      @(posedge i_clk);
      run <= 1'b1;
      while (seen < n)
      begin
         @(posedge i_clk);
         if (instr === 1'b1)
            seen++;
         if (++lim > 50)
         begin
            n_fail++;
            end_of_test();
         end
      end
      run <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
   endtask
   initial
   begin
      repeat (8) @(posedge i_clk);
      i_reset_n <= 1'b1;
      rd(CCR_OFS_GUARD, 8'h00);
      rd(CCR_OFS_SP_LOW, 8'hff);
      rd(CCR_OFS_SP_HIGH, 8'h07);
      rd(CCR_OFS_FLAGS, 8'h00);
      $display("test 1 reset done");
      for (int m = 0; m < 2; m++)
      begin
         slow <= m[0];
         wr(CCR_OFS_GUARD, CCR_CODE_IO);
         retire(3);
         chk(iou, 1'b1);
         chk(inh, 1'b1);
         rd(CCR_OFS_GUARD, 8'h01);
         retire(1);
         chk({iou, inh}, 2'b00);
         rd(CCR_OFS_GUARD, 8'h00);
      end
      $display("test 2 window done");
      for (int k = 0; k < 3; k++)
      begin
         wr(CCR_OFS_GUARD, CCR_CODE_IO);
         pulse(k);
         rd(CCR_OFS_GUARD, 8'h00);
      end
      wr(CCR_OFS_GUARD, CCR_CODE_SPM);
      rd(CCR_OFS_GUARD, 8'h02);
      chk(spu, 1'b1);
      pulse(1);
      rd(CCR_OFS_GUARD, 8'h00);
      wr(CCR_OFS_GUARD, CCR_CODE_SPM);
      retire(4);
      rd(CCR_OFS_GUARD, 8'h00);
      chk({spu, inh}, 2'b00);
      wr(CCR_OFS_GUARD, 8'hff);
      rd(CCR_OFS_GUARD, 8'h00);
      chk({iou, spu, inh}, 3'b000);
      $display("test 3 cancel done");
      wr(8'h05, 8'h5a);
      rd(8'h05, 8'h00);
      wr(CCR_OFS_SP_LOW, 8'haa);
      chk(inh, 1'b1);
      wr(CCR_OFS_SP_HIGH, 8'hff);
      chk(inh, 1'b0);
      rd(CCR_OFS_SP_HIGH, 8'h07);
      chk(sp, 16'h07aa);
      $display("test 4 stack done");
      wr(CCR_OFS_FLAGS, 8'h8c);
      chk(wt, 1'b1);
      rd(CCR_OFS_FLAGS, 8'h8c);
      wr(CCR_OFS_FLAGS, 8'h84);
      chk(wt, 1'b0);
      rd(CCR_OFS_FLAGS, 8'h94);
      pulse(5);
      chk(ien, 1'b1);
      pulse(4);
      chk(ien, 1'b0);
      pulse(3);
      chk(ien, 1'b1);
      bsv <= 1'b1;
      pulse(6);
      chk(bc, 1'b1);
      alu <= 5'h1b;
      pulse(7);
      rd(CCR_OFS_FLAGS, 8'hfb);
      $display("test 5 flags done");
      end_of_test();
   end
endmodule
